// *** design/mdc_defines.svh ***
`ifndef MDC_DEFINES_SVH
`define MDC_DEFINES_SVH

// operation-select word layout
`define MDC_SEL_W      7
`define MDC_SEL_RESET  7'h00
`define MDC_OP_MSB     3
`define MDC_OP_LSB     0
`define MDC_OUT_MSB    6
`define MDC_OUT_LSB    4

// operation field codes
`define MDC_OP_CLEAR   4'h0
`define MDC_OP_AUGEND  4'h1
`define MDC_OP_LOAD0   4'h2
`define MDC_OP_READ    4'h3
`define MDC_OP_MULU    4'h4
`define MDC_OP_MULS    4'h5
`define MDC_OP_MACU    4'h6
`define MDC_OP_MACS    4'h7
`define MDC_OP_DIVU    4'h8
`define MDC_OP_DIVS    4'h9
`define MDC_OP_LOAD1   4'ha

// output field codes
`define MDC_OUT_R0_LO  3'h0
`define MDC_OUT_R0_HI  3'h1
`define MDC_OUT_R1_LO  3'h2
`define MDC_OUT_R1_HI  3'h3

// divider timing: sixteen double-step iterations
`define MDC_DIV_LAST   4'hf
`define MDC_DIV_CNT0   4'h0

// widths and reset values
`define MDC_HALF_W     16
`define MDC_WORD_W     32
`define MDC_HALF_ZERO  16'h0000
`define MDC_WORD_ZERO  32'h0000_0000

`endif

// *** design/mdc_pkg.sv ***
package mdc_pkg;

  // divider sequencer states
  typedef enum logic [1:0] {
    div_idle = 2'b00,
    div_run  = 2'b01,
    div_fix  = 2'b10
  } div_state_t;

endpackage

// *** design/mdc_divider.sv ***
`timescale 1ns/1ps
`default_nettype none
`include "mdc_defines.svh"

module mdc_divider
  import mdc_pkg::*;
(
  // clock and reset
  input wire logic clk_i,
  input wire logic sys_rst_i,
  // request
  input wire logic start_i,
  input wire logic signed_i,
  input wire logic [31:0] dividend_i,
  input wire logic [31:0] divisor_i,
  // answer
  output logic done_o,
  output logic [31:0] quot_o,
  output logic [31:0] rem_o
);

  div_state_t state_ff;
  logic [3:0] cnt_ff;
  logic [63:0] rq_ff;
  logic [31:0] dvs_ff;
  logic neg_q_ff;
  logic neg_r_ff;
  logic [63:0] nxt_rq;

  ////////////////////////////////////////////////////////////////////////////
  // one restoring step: shift in the next dividend bit, subtract if it fits
  function automatic logic [63:0] div_step(input logic [63:0] rq, input logic [31:0] dvs);
    logic [32:0] trial;
    logic [32:0] diff;
    trial = rq[63:31];
    diff = trial - {1'b0, dvs};
    if (!diff[32]) begin
      div_step = {diff[31:0], rq[30:0], 1'b1};
    end else begin
      div_step = {trial[31:0], rq[30:0], 1'b0};
    end
  endfunction

  // two quotient bits per cycle
  always_comb begin
    nxt_rq = div_step(div_step(rq_ff, dvs_ff), dvs_ff);
  end

  ////////////////////////////////////////////////////////////////////////////
  // sequencer: idle, sixteen run cycles, one sign fix-up cycle
  always_ff @(posedge clk_i) begin
    if (sys_rst_i) begin
      state_ff <= div_idle;
      cnt_ff <= `MDC_DIV_CNT0;
    end else begin
      unique case (state_ff)
        div_idle: begin
          cnt_ff <= `MDC_DIV_CNT0;
          if (start_i) begin
            state_ff <= div_run;
          end
        end
        div_run: begin
          cnt_ff <= cnt_ff + 4'h1;
          if (cnt_ff == `MDC_DIV_LAST) begin
            state_ff <= div_fix;
          end
        end
        div_fix: begin
          state_ff <= div_idle;
        end
        default: begin
          state_ff <= div_idle;
        end
      endcase
    end
  end

  // operand capture as magnitudes, then iteration
  always_ff @(posedge clk_i) begin
    if (sys_rst_i) begin
      rq_ff <= {`MDC_WORD_ZERO, `MDC_WORD_ZERO};
      dvs_ff <= `MDC_WORD_ZERO;
      neg_q_ff <= 1'b0;
      neg_r_ff <= 1'b0;
    end else if (state_ff == div_idle && start_i) begin
      rq_ff <= {`MDC_WORD_ZERO, (signed_i && dividend_i[31]) ? -dividend_i : dividend_i};
      dvs_ff <= (signed_i && divisor_i[31]) ? -divisor_i : divisor_i;
      neg_q_ff <= signed_i && (dividend_i[31] ^ divisor_i[31]);
      neg_r_ff <= signed_i && dividend_i[31];
    end else if (state_ff == div_run) begin
      rq_ff <= nxt_rq;
    end
  end

  // sign fix-up and answer; zero divisor gives harmless all-ones quotient, or one for a signed negative dividend
  always_ff @(posedge clk_i) begin
    if (sys_rst_i) begin
      done_o <= 1'b0;
      quot_o <= `MDC_WORD_ZERO;
      rem_o <= `MDC_WORD_ZERO;
    end else begin
      done_o <= (state_ff == div_fix);
      if (state_ff == div_fix) begin
        quot_o <= neg_q_ff ? -rq_ff[31:0] : rq_ff[31:0];
        rem_o <= neg_r_ff ? -rq_ff[63:32] : rq_ff[63:32];
      end
    end
  end

  a_div_done_time: assert property (@(posedge clk_i) disable iff (sys_rst_i) // RULE3
    (state_ff == div_idle && start_i) |-> ##18 done_o)
    else $error("divider answer not on the eighteenth cycle");

endmodule
`default_nettype wire

// *** design/mul_div_coprocessor.sv ***
`timescale 1ns/1ps
`default_nettype none
`include "mdc_defines.svh"

// Summary of operation
// [RULE1] 16x16 multiply, signed or unsigned, to 32 bits in one cycle.
// [RULE2] multiply-accumulate into 32 bits, signed or unsigned, with overflow detection.
// [RULE3] 32 by 32 divide gives quotient and remainder in 17 to 20 cycles.
// [RULE4] no overflow or zero-divisor detection; the processor avoids such divides.
// [RULE5] mode write loads bits six to zero of its source; destination ignored.
// [RULE6] upper select bits choose the returned result half; codes 4 to 7 reserved.
// [RULE7] operation code zero clears both result registers.
// [RULE8] operation code one loads a 16-bit augend into result zero low half.
// [RULE9] code 2 loads 32 bits into result zero, code a into result one.
// [RULE10] code 3 returns the selected half without computing or changing anything.
// [RULE11] codes 4 and 5 put the operand product into result zero.
// [RULE12] code 6 is unsigned multiply-accumulate, code 7 signed.
// [RULE13] a multiply returns the product half named by the output field.
// [RULE14] result registers hold their value until another operation overwrites them.
// [RULE15] processor sets a multiply mode, then sends one operate with both operands.
// [RULE16] for the upper half the processor writes mode 13h and operates again.
// [RULE17] divide needs dividend preloaded; quotient lands in zero, remainder in one.
// [RULE18] reserved operation or output codes leave results alone, return harmless data.
module mul_div_coprocessor
  import mdc_pkg::*;
(
  // clock and reset
  input wire logic clk_i,
  input wire logic sys_rst_i,
  // mode write instruction
  input wire logic mode_write_i,
  input wire logic [15:0] mode_data_i,
  // operate and preload instructions, destination and source operands
  input wire logic operate_i,
  input wire logic preload_i,
  input wire logic [15:0] opd_i,
  input wire logic [15:0] ops_i,
  // answer to the processor
  output logic [15:0] result_o,
  output logic result_valid_o,
  output logic busy_o,
  output logic mac_ovf_o
);

  logic [6:0] mode_ff;
  logic [31:0] result_register_zero_ff;
  logic [31:0] result_register_one_ff;
  logic mac_ovf_ff;
  logic div_busy_ff;
  logic [2:0] div_out_ff;
  logic [31:0] nxt_result_register_zero;
  logic [31:0] nxt_result_register_one;
  logic nxt_ovf;
  logic [3:0] op;
  logic [2:0] out_sel;
  logic op_go;
  logic pre_go;
  logic div_start;
  logic div_done;
  logic [31:0] div_quot;
  logic [31:0] div_rem;
  logic [31:0] prod_u;
  logic [31:0] prod_s;
  logic [32:0] mac_u;
  logic [31:0] mac_s;
  logic [31:0] chk_dvd_ff;
  logic [31:0] chk_dvs_ff;
  logic chk_udiv_ff;

  ////////////////////////////////////////////////////////////////////////////
  // half-word selector for the returned value
  function automatic logic [15:0] half_sel(input logic [2:0] sel, input logic [31:0] r0,
                                           input logic [31:0] r1);
    unique case (sel)
      `MDC_OUT_R0_LO: half_sel = r0[15:0];
      `MDC_OUT_R0_HI: half_sel = r0[31:16];
      `MDC_OUT_R1_LO: half_sel = r1[15:0];
      `MDC_OUT_R1_HI: half_sel = r1[31:16];
      default: half_sel = `MDC_HALF_ZERO;
    endcase
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // operation-select register, destination operand not used
  always_ff @(posedge clk_i) begin
    if (sys_rst_i) begin
      mode_ff <= `MDC_SEL_RESET;
    end else if (mode_write_i) begin
      mode_ff <= mode_data_i[`MDC_OUT_MSB:`MDC_OP_LSB]; // RULE5
    end
  end

  assign op = mode_ff[`MDC_OP_MSB:`MDC_OP_LSB];
  assign out_sel = mode_ff[`MDC_OUT_MSB:`MDC_OUT_LSB];

  // request acceptance; operates and preloads are ignored while a divide runs
  assign busy_o = div_busy_ff;
  assign op_go = operate_i && !div_busy_ff;
  assign pre_go = preload_i && !div_busy_ff && !operate_i;
  assign div_start = op_go && (op == `MDC_OP_DIVU || op == `MDC_OP_DIVS);

  ////////////////////////////////////////////////////////////////////////////
  // single-cycle multiplier and accumulators
  // operands widened before the product so no upper bits are lost
  assign prod_u = {`MDC_HALF_ZERO, opd_i} * {`MDC_HALF_ZERO, ops_i}; // RULE1
  assign prod_s = $signed({{`MDC_HALF_W{opd_i[15]}}, opd_i}) * // RULE1
                  $signed({{`MDC_HALF_W{ops_i[15]}}, ops_i});
  assign mac_u = {1'b0, result_register_zero_ff} + {1'b0, prod_u};
  assign mac_s = result_register_zero_ff + prod_s;

  // next result register contents per operation code
  always_comb begin
    nxt_result_register_zero = result_register_zero_ff; // RULE14
    nxt_result_register_one = result_register_one_ff;
    nxt_ovf = mac_ovf_ff;
    if (op_go || pre_go) begin
      unique case (op)
        `MDC_OP_CLEAR: begin
          if (op_go) begin
            nxt_result_register_zero = `MDC_WORD_ZERO; // RULE7
            nxt_result_register_one = `MDC_WORD_ZERO; // RULE7
            nxt_ovf = 1'b0;
          end
        end
        `MDC_OP_AUGEND: begin
          nxt_result_register_zero = {result_register_zero_ff[31:16], ops_i}; // RULE8
        end
        `MDC_OP_LOAD0: begin
          nxt_result_register_zero = {opd_i, ops_i}; // RULE9
        end
        `MDC_OP_LOAD1: begin
          nxt_result_register_one = {opd_i, ops_i}; // RULE9
        end
        `MDC_OP_MULU: begin
          if (op_go) begin
            nxt_result_register_zero = prod_u; // RULE11
          end
        end
        `MDC_OP_MULS: begin
          if (op_go) begin
            nxt_result_register_zero = prod_s; // RULE11
          end
        end
        `MDC_OP_MACU: begin
          if (op_go) begin
            nxt_result_register_zero = mac_u[31:0]; // RULE12
            nxt_ovf = mac_u[32]; // RULE2
          end
        end
        `MDC_OP_MACS: begin
          if (op_go) begin
            nxt_result_register_zero = mac_s; // RULE12
            nxt_ovf = (result_register_zero_ff[31] == prod_s[31]) && (mac_s[31] != result_register_zero_ff[31]); // RULE2
          end
        end
        default: begin
          // read, divide start and reserved codes keep both registers
          nxt_result_register_zero = result_register_zero_ff; // RULE10 RULE18
          nxt_result_register_one = result_register_one_ff;
        end
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // result registers; divider answer overwrites both
  always_ff @(posedge clk_i) begin
    if (sys_rst_i) begin
      result_register_zero_ff <= `MDC_WORD_ZERO;
      result_register_one_ff <= `MDC_WORD_ZERO;
      mac_ovf_ff <= 1'b0;
    end else if (div_done) begin
      result_register_zero_ff <= div_quot; // RULE17
      result_register_one_ff <= div_rem; // RULE17
    end else begin
      result_register_zero_ff <= nxt_result_register_zero;
      result_register_one_ff <= nxt_result_register_one;
      mac_ovf_ff <= nxt_ovf;
    end
  end

  assign mac_ovf_o = mac_ovf_ff;

  // divide in progress; output field captured at start
  always_ff @(posedge clk_i) begin
    if (sys_rst_i) begin
      div_busy_ff <= 1'b0;
      div_out_ff <= `MDC_OUT_R0_LO;
    end else if (div_start) begin
      div_busy_ff <= 1'b1;
      div_out_ff <= out_sel;
    end else if (div_done) begin
      div_busy_ff <= 1'b0;
    end
  end

  // returned half-word to the destination register
  always_ff @(posedge clk_i) begin
    if (sys_rst_i) begin
      result_o <= `MDC_HALF_ZERO;
      result_valid_o <= 1'b0;
    end else if (div_done) begin
      result_o <= half_sel(div_out_ff, div_quot, div_rem); // RULE3
      result_valid_o <= 1'b1;
    end else if (op_go && !div_start) begin
      result_o <= half_sel(out_sel, nxt_result_register_zero, nxt_result_register_one); // RULE6 RULE13
      result_valid_o <= 1'b1;
    end else begin
      result_valid_o <= 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // iterative divider; dividend is the preloaded result zero
  // a zero divisor is not trapped; the processor must keep it out
  mdc_divider u_divider (
    .clk_i(clk_i),
    .sys_rst_i(sys_rst_i),
    .start_i(div_start), // RULE17
    .signed_i(op == `MDC_OP_DIVS),
    .dividend_i(result_register_zero_ff),
    .divisor_i({opd_i, ops_i}), // RULE4
    .done_o(div_done),
    .quot_o(div_quot),
    .rem_o(div_rem)
  );

  ////////////////////////////////////////////////////////////////////////////
  // helper capture of unsigned divide operands for checking
  always_ff @(posedge clk_i) begin
    if (sys_rst_i) begin
      chk_dvd_ff <= `MDC_WORD_ZERO;
      chk_dvs_ff <= `MDC_WORD_ZERO;
      chk_udiv_ff <= 1'b0;
    end else if (div_start) begin
      chk_dvd_ff <= result_register_zero_ff;
      chk_dvs_ff <= {opd_i, ops_i};
      chk_udiv_ff <= (op == `MDC_OP_DIVU);
    end
  end

  // divide answer window, in cycles after the start edge
  localparam int div_lo = 17;
  localparam int div_hi = 20;

  // all checks run on the core clock and pause in reset
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (sys_rst_i);

  a_mul_unsigned: assert property ((op_go && op == `MDC_OP_MULU) |=> // RULE1 RULE11
    (result_valid_o && result_register_zero_ff == {`MDC_HALF_ZERO, $past(opd_i)} * {`MDC_HALF_ZERO, $past(ops_i)}))
    else $error("unsigned product not in result zero after one cycle");

  a_mul_signed: assert property ((op_go && op == `MDC_OP_MULS) |=> // RULE11
    (result_register_zero_ff == 32'($signed($past(opd_i)) * $signed($past(ops_i)))))
    else $error("signed product wrong in result zero");

  a_mac_sum: assert property ((op_go && op == `MDC_OP_MACU) |=> // RULE2 RULE12
    ({mac_ovf_o, result_register_zero_ff} == {1'b0, $past(result_register_zero_ff)} + {17'h0_0000, $past(opd_i)} * {17'h0_0000, $past(ops_i)}))
    else $error("unsigned accumulate or carry wrong");

  a_div_latency: assert property (div_start |-> ##[div_lo:div_hi] result_valid_o) // RULE3
    else $error("divide answer outside 17 to 20 cycles");

  a_busy_start: assert property (div_start |=> busy_o) // RULE3
    else $error("busy not raised after a divide start");

  a_div_result: assert property ((div_done && chk_udiv_ff && chk_dvs_ff != `MDC_WORD_ZERO) |=> // RULE17
    (result_register_zero_ff * chk_dvs_ff + result_register_one_ff == chk_dvd_ff && result_register_one_ff < chk_dvs_ff))
    else $error("unsigned quotient and remainder inconsistent");

  a_clear_both: assert property ((op_go && op == `MDC_OP_CLEAR) |=> // RULE7
    (result_register_zero_ff == `MDC_WORD_ZERO && result_register_one_ff == `MDC_WORD_ZERO))
    else $error("clear left a result register nonzero");

  a_augend_load: assert property ((op_go && op == `MDC_OP_AUGEND) |=> // RULE8
    (result_register_zero_ff == {$past(result_register_zero_ff[31:16]), $past(ops_i)} && $stable(result_register_one_ff)))
    else $error("augend load wrong");

  a_word_load: assert property ((op_go && op == `MDC_OP_LOAD1) |=> // RULE9
    (result_register_one_ff == {$past(opd_i), $past(ops_i)} && $stable(result_register_zero_ff)))
    else $error("result one load wrong");

  a_read_hold: assert property ((op_go && op == `MDC_OP_READ) |=> // RULE10 RULE14
    ($stable(result_register_zero_ff) && $stable(result_register_one_ff) && result_valid_o &&
     result_o == half_sel($past(out_sel), result_register_zero_ff, result_register_one_ff)))
    else $error("read changed results or returned wrong half");

  a_half_select: assert property ((op_go && op == `MDC_OP_MULU && out_sel == `MDC_OUT_R0_HI) |=> // RULE6 RULE13
    (result_o == result_register_zero_ff[31:16]))
    else $error("high product half not returned");

  a_reserved_hold: assert property ((op_go && op > `MDC_OP_LOAD1) |=> // RULE18
    ($stable(result_register_zero_ff) && $stable(result_register_one_ff)))
    else $error("reserved code altered a result register");

  c_multiply: cover property (op_go && op == `MDC_OP_MULS ##1 result_valid_o);
  c_divide: cover property (div_start ##[div_lo:div_hi] result_valid_o);
  c_mac_overflow: cover property (op_go && op == `MDC_OP_MACS ##1 mac_ovf_o);
  c_clear: cover property (op_go && op == `MDC_OP_CLEAR);

endmodule
`default_nettype wire

// *** bench/mdc_cpu_model.sv ***
`timescale 1ns/1ps
`default_nettype none
module mdc_cpu_model (
  // clock
  input wire logic clk_i,
  // coprocessor answer
  input wire logic [15:0] result_i,
  input wire logic result_valid_i,
  // coprocessor requests
  output logic mode_write_o,
  output logic [15:0] mode_data_o,
  output logic operate_o,
  output logic preload_o,
  output logic [15:0] opd_o,
  output logic [15:0] ops_o
);
  // idle bus at time zero
  initial begin
    mode_write_o = 1'b0;
    mode_data_o = 16'h0000;
    operate_o = 1'b0;
    preload_o = 1'b0;
    opd_o = 16'h0000;
    ops_o = 16'h0000;
  end
  // mode write: only the low seven bits count, the rest is junk
  task automatic set_mode(input logic [6:0] m, input logic [8:0] junk);
    @(negedge clk_i);
    mode_write_o = 1'b1;
    mode_data_o = {junk, m};
    @(negedge clk_i);
    mode_write_o = 1'b0;
    mode_data_o = ~mode_data_o;
  endtask
  // one operate after a mode write; the answer is looked for at falling edges, for up to 40 cycles
  task automatic operate(input logic [15:0] a, input logic [15:0] b, output logic [15:0] res, output int lat);
    @(negedge clk_i);
    operate_o = 1'b1;
    opd_o = a;
    ops_o = b;
    @(negedge clk_i);
    operate_o = 1'b0;
    opd_o = ~a;
    ops_o = ~b;
    lat = 1;
    while (result_valid_i !== 1'b1 && lat < 40) begin
      @(negedge clk_i);
      lat++;
    end
    res = result_i;
  endtask
  // preload pulse, no answer expected; dividend goes in this way
  task automatic preload(input logic [15:0] a, input logic [15:0] b);
    @(negedge clk_i);
    preload_o = 1'b1;
    opd_o = a;
    ops_o = b;
    @(negedge clk_i);
    preload_o = 1'b0;
    opd_o = ~a;
    ops_o = ~b;
  endtask
endmodule
`default_nettype wire

// *** bench/mul_div_coprocessor_tb.sv ***
`timescale 1ns/1ps
`default_nettype none
module mul_div_coprocessor_tb;
  logic clk_i = 1'b0;
  logic sys_rst_i = 1'b1;
  logic mode_write, operate, preload, result_valid_o, busy_o, mac_ovf_o;
  logic [15:0] mode_data, opd, ops, result_o, a, b;
  logic [31:0] e0, e1, dv;
  logic eovf;
  int err_total = 0;
  int comparisons = 0;
  int seed = 77;
  int cycles = 0;
  int busy_cnt = 0;
  ////////////////////////////////////////////////////////////////////////
  // clock, hang guard
  always #5 clk_i = ~clk_i;
  always @(posedge clk_i) begin
    cycles++;
    if (cycles == 20000) begin
      err_total++;
      end_sim();
    end
  end
  // busy cycles counted at falling edges, where outputs have settled
  always @(negedge clk_i) begin
    if (busy_o === 1'b1) begin
      busy_cnt++;
    end
  end
  mdc_cpu_model mdc_cpu_model_inst (.clk_i(clk_i), .result_i(result_o), .result_valid_i(result_valid_o),
    .mode_write_o(mode_write), .mode_data_o(mode_data), .operate_o(operate), .preload_o(preload),
    .opd_o(opd), .ops_o(ops));
  mul_div_coprocessor mul_div_coprocessor_inst (.clk_i(clk_i), .sys_rst_i(sys_rst_i),
    .mode_write_i(mode_write), .mode_data_i(mode_data), .operate_i(operate), .preload_i(preload),
    .opd_i(opd), .ops_i(ops), .result_o(result_o), .result_valid_o(result_valid_o), .busy_o(busy_o),
    .mac_ovf_o(mac_ovf_o));
  ////////////////////////////////////////////////////////////////////////
  // verdict and compare
  task automatic end_sim();
    $display("comparisons %0d mismatches %0d", comparisons, err_total);
    if (err_total == 0 && comparisons > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask
  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    comparisons++;
    if (got !== exp) begin
      err_total++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
    end
  endtask
  // expected half for an output field; reserved codes read zero
  function automatic logic [15:0] half(input logic [2:0] o);
    case (o)
      3'h0: return e0[15:0];
      3'h1: return e0[31:16];
      3'h2: return e1[15:0];
      3'h3: return e1[31:16];
      default: return 16'h0000;
    endcase
  endfunction
  // reference model of the result registers
  task automatic ref_op(input logic [3:0] op, input logic [15:0] x, input logic [15:0] y);
    logic [31:0] p;
    logic [32:0] s;
    p = op[0] ? $signed({{16{x[15]}}, x}) * $signed({{16{y[15]}}, y}) : {16'h0000, x} * {16'h0000, y};
    s = {1'b0, e0} + {1'b0, p};
    case (op)
      4'h0: {e0, e1, eovf} = '0;
      4'h1: e0[15:0] = y;
      4'h2: e0 = {x, y};
      4'h4, 4'h5: e0 = p;
      4'h6: {eovf, e0} = s;
      4'h7: begin
        eovf = (e0[31] == p[31]) && (s[31] != e0[31]);
        e0 = s[31:0];
      end
      4'h8: {e0, e1} = {e0 / {x, y}, e0 % {x, y}};
      4'h9: {e0, e1} = {$signed(e0) / $signed({x, y}), $signed(e0) % $signed({x, y})};
      4'ha: e1 = {x, y};
      default: ;
    endcase
  endtask
  // mode write, operate, then check answer, latency and overflow flag
  task automatic do_op(input logic [6:0] m, input logic [15:0] x, input logic [15:0] y);
    logic [15:0] got;
    int lat;
    int b0;
    mdc_cpu_model_inst.set_mode(m, 9'($random(seed)));
    b0 = busy_cnt;
    mdc_cpu_model_inst.operate(x, y, got, lat);
    ref_op(m[3:0], x, y);
    chk("result half", {16'h0000, half(m[6:4])}, {16'h0000, got});
    chk("latency", (m[3:1] == 3'h4) ? 19 : 1, lat);
    chk("mac overflow", {31'h0, eovf}, {31'h0, mac_ovf_o});
    chk("busy cycles", (m[3:1] == 3'h4) ? 18 : 0, busy_cnt - b0);
  endtask
  task automatic do_preload(input logic [6:0] m, input logic [15:0] x, input logic [15:0] y);
    mdc_cpu_model_inst.set_mode(m, 9'($random(seed)));
    mdc_cpu_model_inst.preload(x, y);
    ref_op(m[3:0], x, y);
  endtask
  // read all four halves without computing
  task automatic read_all();
    for (int k = 0; k < 4; k++) begin
      do_op({3'(k), 4'h3}, 16'($random(seed)), 16'($random(seed)));
    end
  endtask
  ////////////////////////////////////////////////////////////////////////
  // main sequence
  initial begin
    {e0, e1, eovf} = '0;
    repeat (3) @(negedge clk_i);
    sys_rst_i = 1'b0;
    read_all();
    // multiplies in all four modes, extremes first
    for (int i = 0; i < 24; i++) begin
      a = (i < 4) ? 16'hffff : (i < 8) ? 16'h8000 : 16'($random(seed));
      b = (i < 8) ? 16'hffff : 16'($random(seed));
      do_op({2'b00, i[1], 3'h2, i[0]}, a, b);
      do_op(7'h13, a, b);
    end
    // loads and augend, by preload and by operate
    do_preload(7'h02, 16'($random(seed)), 16'($random(seed)));
    do_op(7'h0a, 16'($random(seed)), 16'($random(seed)));
    do_preload(7'h01, 16'($random(seed)), 16'($random(seed)));
    do_op(7'h31, 16'($random(seed)), 16'($random(seed)));
    read_all();
    do_op(7'h00, 16'hffff, 16'hffff);
    read_all();
    // accumulate onto random seeds in every mac mode
    for (int i = 0; i < 16; i++) begin
      do_preload(7'h02, 16'($random(seed)), 16'($random(seed)));
      do_op({2'b00, i[1], 3'h3, i[0]}, 16'($random(seed)), 16'($random(seed)));
      do_op({2'b00, i[2], 3'h3, i[3]}, 16'($random(seed)), 16'($random(seed)));
    end
    // divides with every output field, small and large divisors
    for (int i = 0; i < 16; i++) begin
      do_preload(7'h02, 16'($random(seed)), 16'($random(seed)));
      dv = i[3] ? 32'($random(seed)) : {16'h0000, 16'($random(seed))};
      if (dv == 32'h0000_0000 || (i[0] && e0 == 32'h8000_0000 && dv == 32'hffff_ffff)) begin
        dv = 32'h0000_0003;
      end
      do_op({1'b0, i[2:1], 4'h8 | 4'(i[0])}, dv[31:16], dv[15:0]);
      read_all();
    end
    // reserved output field and reserved operation
    do_op(7'h43, 16'($random(seed)), 16'($random(seed)));
    do_op(7'h0b, 16'($random(seed)), 16'($random(seed)));
    read_all();
    end_sim();
  end
endmodule
`default_nettype wire
